/* File: core/trace_capture_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
`include "trace_params.svh"
module trace_capture_ctrl #(
  parameter int          ADDR_W   = `TRC_ADDR_W,
  parameter int          DATA_W   = `TRC_DATA_W,
  parameter logic [31:0] ID_VALUE = 32'h0000_0001  // arbitrary value
) (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  // trace source and formatter
  input  wire logic [2:0]           packet_width_select,
  input  wire logic                 generic_source,
  input  wire logic                 trigger_event,
  input  wire logic                 word_complete_strobe,
  input  wire logic [DATA_W-1:0]    trace_packet_bus,
  // format and status
  output logic [5:0]                packet_bits,
  output logic                      width_reserved,
  output logic                      capture_enable_bit,
  output logic                      trigger_seen,
  output logic                      acquisition_done_flag,
  // trace ram
  output trace_pkg::ram_req_t       ram_req,
  input  wire logic [DATA_W-1:0]    ram_dout,
  // self-test controller
  input  wire logic                 selftest_takeover,
  input  wire trace_pkg::ram_req_t  selftest_req,
  output logic [DATA_W-1:0]         selftest_dout,
  // test access port
  input  wire logic                 tck,
  input  wire logic                 tms,
  input  wire logic                 tdi,
  output logic                      tdo,
  output logic                      tdo_oe
);
  import trace_pkg::*;

  // the ram request struct is sized by the package, so only those widths fit
  if (ADDR_W != `TRC_ADDR_W || DATA_W != `TRC_DATA_W || DATA_W > 32) begin : g_width_check
    $error("widths must match the ram request struct");
  end


  logic [ADDR_W-1:0]   capture_address_pointer;
  logic [ADDR_W-1:0]   readout_address_pointer;
  logic [ADDR_W-1:0]   post_trigger_counter;
  logic                readout_update_pulse;
  logic                capturing;
  logic                capture_pointer_increment;
  logic [2:0]          s1, s2, s3, lvl;
  logic                tck_rise;
  logic                tms_l, tdi_l;
  tap_state_t          state, next_state;
  logic [3:0]          ir, ir_sh;
  logic [4:0]          chain_sel;
  logic [39:0]         dr, next_dr;
  logic [5:0]          dr_len;
  logic [31:0]         rd_data, rd_mux;
  logic                acc_go, wr_go, rd_go;
  logic [6:0]          acc_addr;
  logic [31:0]         wdata;
  logic                rd_load, readout_increment;
  logic                wp_load, cnt_load;

  // packet width decode, registered
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      packet_bits    <= 6'h00;
      width_reserved <= 1'b0;
    end else if (generic_source) begin
      packet_bits    <= 6'(DATA_W);
      width_reserved <= 1'b0;
    end else begin
      width_reserved <= 1'b0;
      case (packet_width_select)
        `TRC_PW_4:  packet_bits <= `TRC_BITS_4;
        `TRC_PW_8:  packet_bits <= `TRC_BITS_8;
        `TRC_PW_16: packet_bits <= `TRC_BITS_16;
        default: begin
          packet_bits    <= 6'h00;
          width_reserved <= 1'b1;
        end
      endcase
    end
  end

  // capture side
  assign capturing = capture_enable_bit && !acquisition_done_flag;
  // strobe is single-cycle from the formatter, so one word per pulse
  assign capture_pointer_increment = capturing && word_complete_strobe;

  always_ff @(posedge sys_clk) begin
    if (!reset_n || !capture_enable_bit) begin
      trigger_seen <= 1'b0;
    end else if (capturing && trigger_event) begin
      trigger_seen <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      post_trigger_counter <= '0;
    end else if (cnt_load) begin
      post_trigger_counter <= wdata[ADDR_W-1:0];
    end else if (trigger_seen && capture_pointer_increment && post_trigger_counter != '0) begin
      post_trigger_counter <= post_trigger_counter - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n || !capture_enable_bit) begin
      acquisition_done_flag <= 1'b0;
    end else if (trigger_seen && post_trigger_counter == '0) begin
      acquisition_done_flag <= 1'b1;
    end
  end

  // only scan writes and captured words move it; foreign ram writes cannot
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      capture_address_pointer <= '0;
    end else if (wp_load) begin
      capture_address_pointer <= wdata[ADDR_W-1:0];
    end else if (capture_pointer_increment) begin
      capture_address_pointer <= capture_address_pointer + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      readout_address_pointer <= '0;
    end else if (rd_load) begin
      readout_address_pointer <= wdata[ADDR_W-1:0];
    end else if (readout_increment) begin
      readout_address_pointer <= readout_address_pointer + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      readout_update_pulse <= 1'b0;
    end else begin
      readout_update_pulse <= rd_load || readout_increment;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      capture_enable_bit <= 1'b0;
    end else if (wr_go && acc_addr == `TRC_REG_CTRL) begin
      capture_enable_bit <= wdata[0];
    end
  end

  // ram port
  always_comb begin
    if (selftest_takeover) begin
      ram_req = selftest_req;
    end else begin
      ram_req.ce   = readout_update_pulse || capture_pointer_increment;
      ram_req.we   = capture_pointer_increment;
      ram_req.addr = capture_enable_bit ? capture_address_pointer
                                        : readout_address_pointer;
      ram_req.din  = trace_packet_bus;
    end
  end
  assign selftest_dout = ram_dout;

  // tap pins: three stages, a change counts when stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s1  <= 3'h0;
      s2  <= 3'h0;
      s3  <= 3'h0;
      lvl <= 3'h0;
    end else begin
      s1  <= {tdi, tms, tck};
      s2  <= s1;
      s3  <= s2;
      lvl <= (s2 & s3) | (lvl & (s2 ^ s3));
    end
  end
  assign tck_rise = s2[0] && s3[0] && !lvl[0];
  assign tms_l    = lvl[1];
  assign tdi_l    = lvl[2];

  always_comb begin
    case (state)
      st_reset:  next_state = tms_l ? st_reset  : st_idle;
      st_idle:   next_state = tms_l ? st_sel_dr : st_idle;
      st_sel_dr: next_state = tms_l ? st_sel_ir : st_cap_dr;
      st_cap_dr: next_state = tms_l ? st_ex1_dr : st_sh_dr;
      st_sh_dr:  next_state = tms_l ? st_ex1_dr : st_sh_dr;
      st_ex1_dr: next_state = tms_l ? st_upd_dr : st_pa_dr;
      st_pa_dr:  next_state = tms_l ? st_ex2_dr : st_pa_dr;
      st_ex2_dr: next_state = tms_l ? st_upd_dr : st_sh_dr;
      st_upd_dr: next_state = tms_l ? st_sel_dr : st_idle;
      st_sel_ir: next_state = tms_l ? st_reset  : st_cap_ir;
      st_cap_ir: next_state = tms_l ? st_ex1_ir : st_sh_ir;
      st_sh_ir:  next_state = tms_l ? st_ex1_ir : st_sh_ir;
      st_ex1_ir: next_state = tms_l ? st_upd_ir : st_pa_ir;
      st_pa_ir:  next_state = tms_l ? st_ex2_ir : st_pa_ir;
      st_ex2_ir: next_state = tms_l ? st_upd_ir : st_sh_ir;
      st_upd_ir: next_state = tms_l ? st_sel_dr : st_idle;
      default:   next_state = st_reset;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state <= st_reset;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  // instruction register
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ir_sh <= `TRC_IR_CAPTURE;
      ir    <= `TRC_IR_RESET;
    end else if (tck_rise) begin
      case (state)
        st_reset:  ir    <= `TRC_IR_RESET;
        st_cap_ir: ir_sh <= `TRC_IR_CAPTURE;
        st_sh_ir:  ir_sh <= {tdi_l, ir_sh[3:1]};
        st_upd_ir: ir    <= ir_sh;
        default:   ir    <= ir;
      endcase
    end
  end

  // data path length per instruction
  always_comb begin
    case (ir)
      `TRC_INS_SCAN_N: dr_len = `TRC_LEN_SEL;
      `TRC_INS_CHAIN:  dr_len = (chain_sel == `TRC_CHAIN0) ? `TRC_LEN_CHAIN0
                                                           : `TRC_LEN_BYPASS;
      `TRC_INS_IDCODE: dr_len = `TRC_LEN_ID;
      default:         dr_len = `TRC_LEN_BYPASS;
    endcase
  end

  always_comb begin
    next_dr         = dr >> 1;
    next_dr[dr_len - 6'h01] = tdi_l;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      dr <= '0;
    end else if (tck_rise && state == st_cap_dr) begin
      case (ir)
        `TRC_INS_SCAN_N: dr <= {35'h0, chain_sel};
        `TRC_INS_CHAIN:  dr <= {8'h00, rd_data};
        `TRC_INS_IDCODE: dr <= {8'h00, ID_VALUE};
        default:         dr <= '0;
      endcase
    end else if (tck_rise && state == st_sh_dr) begin
      dr <= next_dr;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      chain_sel <= `TRC_SEL_RESET;
    end else if (tck_rise && state == st_upd_dr && ir == `TRC_INS_SCAN_N) begin
      chain_sel <= dr[4:0];
    end
  end

  // register access at update-dr of chain 0
  assign acc_go   = tck_rise && state == st_upd_dr && ir == `TRC_INS_CHAIN
                    && chain_sel == `TRC_CHAIN0;
  assign wr_go    = acc_go && dr[`TRC_RW_BIT];
  assign rd_go    = acc_go && !dr[`TRC_RW_BIT];
  assign acc_addr = dr[`TRC_ADDR_HI:`TRC_ADDR_LO];
  assign wdata    = dr[31:0];
  assign rd_load  = wr_go && acc_addr == `TRC_REG_RDPTR;
  assign readout_increment = rd_go && acc_addr == `TRC_REG_RAMDATA;
  assign wp_load  = wr_go && acc_addr == `TRC_REG_WRPTR;
  assign cnt_load = wr_go && acc_addr == `TRC_REG_TRIGCNT;

  // pointer reads do not move the pointer
  always_comb begin
    case (acc_addr)
      `TRC_REG_STATUS:  rd_mux = {30'h0, acquisition_done_flag, trigger_seen};
      `TRC_REG_RAMDATA: rd_mux = 32'(ram_dout);
      `TRC_REG_RDPTR:   rd_mux = 32'(readout_address_pointer);
      `TRC_REG_WRPTR:   rd_mux = 32'(capture_address_pointer);
      `TRC_REG_TRIGCNT: rd_mux = 32'(post_trigger_counter);
      `TRC_REG_CTRL:    rd_mux = {31'h0, capture_enable_bit};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rd_data <= 32'h0000_0000;
    end else if (rd_go) begin
      rd_data <= rd_mux;
    end
  end

  assign tdo_oe = (state == st_sh_dr) || (state == st_sh_ir);
  assign tdo    = (state == st_sh_ir) ? ir_sh[0] : dr[0];

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_ptr_update;
    rd_load || readout_increment;
  endsequence
  sequence s_word_write;
    capture_pointer_increment && !wp_load;
  endsequence

  chk_flags_clear: assert property (!capture_enable_bit |=> !trigger_seen && !acquisition_done_flag)
    else $error("flags not cleared while capture off");
  chk_trig_sets: assert property (capturing && trigger_event |=> trigger_seen)
    else $error("trigger flag not set");
  chk_cnt_dec: assert property (trigger_seen && capture_pointer_increment && !cnt_load
      && post_trigger_counter != '0
      |=> post_trigger_counter == ADDR_W'($past(post_trigger_counter) - 1'b1))
    else $error("post-trigger counter did not decrement");
  chk_done_blocks: assert property (acquisition_done_flag && !selftest_takeover |-> !ram_req.we)
    else $error("write after acquisition done");
  chk_wp_inc: assert property (s_word_write
      |=> capture_address_pointer == ADDR_W'($past(capture_address_pointer) + 1'b1))
    else $error("capture pointer did not increment");
  chk_upd_pulse: assert property (s_ptr_update ##1 !rd_load && !readout_increment
      |-> readout_update_pulse ##1 !readout_update_pulse)
    else $error("readout update pulse wrong length");
  chk_ram_select: assert property (s_ptr_update |=> ram_req.ce || selftest_takeover)
    else $error("ram select missing after pointer update");
  chk_addr_src: assert property (!selftest_takeover && capture_enable_bit
      |-> ram_req.addr == capture_address_pointer)
    else $error("wrong ram address source");
  chk_ir_cap: assert property (tck_rise && state == st_cap_ir |=> ir_sh == `TRC_IR_CAPTURE)
    else $error("ir capture value wrong");
  chk_bypass_bit: assert property (tck_rise && state == st_sh_dr && ir == `TRC_INS_BYPASS
      |=> dr[0] == $past(tdi_l))
    else $error("bypass path wrong");
endmodule
`default_nettype wire

/* File: core/trace_params.svh */
`ifndef TRACE_PARAMS_SVH
`define TRACE_PARAMS_SVH
`define TRC_ADDR_W      10
`define TRC_DATA_W      32
`define TRC_PW_4        3'h0
`define TRC_PW_8        3'h1
`define TRC_PW_16       3'h2
`define TRC_BITS_4      6'h04
`define TRC_BITS_8      6'h08
`define TRC_BITS_16     6'h10
`define TRC_IR_W        4
`define TRC_IR_RESET    4'hE
`define TRC_IR_CAPTURE  4'h1
`define TRC_INS_SCAN_N  4'h2
`define TRC_INS_CHAIN   4'hC
`define TRC_INS_IDCODE  4'hE
`define TRC_INS_BYPASS  4'hF
`define TRC_SEL_W       5
`define TRC_SEL_RESET   5'h00
`define TRC_CHAIN0      5'h00
`define TRC_LEN_CHAIN0  6'h28
`define TRC_LEN_SEL     6'h05
`define TRC_LEN_ID      6'h20
`define TRC_LEN_BYPASS  6'h01
`define TRC_RW_BIT      39
`define TRC_ADDR_HI     38
`define TRC_ADDR_LO     32
`define TRC_REG_STATUS  7'h01
`define TRC_REG_RAMDATA 7'h03
`define TRC_REG_RDPTR   7'h04
`define TRC_REG_WRPTR   7'h05
`define TRC_REG_TRIGCNT 7'h06
`define TRC_REG_CTRL    7'h08
`endif

/* File: core/trace_pkg.sv */
`include "trace_params.svh"
package trace_pkg;
  typedef enum logic [15:0] {
    st_reset   = 16'h0001, st_idle    = 16'h0002, st_sel_dr  = 16'h0004,
    st_cap_dr  = 16'h0008, st_sh_dr   = 16'h0010, st_ex1_dr  = 16'h0020,
    st_pa_dr   = 16'h0040, st_ex2_dr  = 16'h0080, st_upd_dr  = 16'h0100,
    st_sel_ir  = 16'h0200, st_cap_ir  = 16'h0400, st_sh_ir   = 16'h0800,
    st_ex1_ir  = 16'h1000, st_pa_ir   = 16'h2000, st_ex2_ir  = 16'h4000,
    st_upd_ir  = 16'h8000
  } tap_state_t;
  typedef struct packed {
    logic                   ce;
    logic                   we;
    logic [`TRC_ADDR_W-1:0] addr;
    logic [`TRC_DATA_W-1:0] din;
  } ram_req_t;
endpackage

/* File: verif/trace_ram_model.sv */
`timescale 1ns/10ps
`default_nettype none
module trace_ram_model #(
  parameter int DEPTH = 1024
) (
  // clock
  input  wire logic                sys_clk,
  // ram port
  input  wire trace_pkg::ram_req_t ram_req,
  output logic [31:0]              ram_dout
);
  import trace_pkg::*;
  logic [31:0] mem [DEPTH];
  // single port: a write cycle leaves the read output as it was
  always_ff @(posedge sys_clk) begin
    if (ram_req.ce && ram_req.we) begin
      mem[ram_req.addr] <= ram_req.din;
    end else if (ram_req.ce) begin
      ram_dout <= mem[ram_req.addr];
    end
  end
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "trace_params.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %0t got %0h exp %0h", $time, (g), (e)); end end
module tb_top;
  import trace_pkg::*;
  localparam logic [31:0] ID = 32'h5A5A_0F0F;  // arbitrary value
  logic sys_clk = 0, reset_n = 0, tck = 0, tms = 1, tdi = 0;
  logic [2:0] packet_width_select = 3'h1;
  logic generic_source = 0, trigger_event = 0, word_complete_strobe = 0;
  logic selftest_takeover = 0;
  logic [31:0] trace_packet_bus = 32'h0, ram_dout, selftest_dout, seed = 32'hDB3ECA5F;
  ram_req_t ram_req, selftest_req = '0;
  logic [5:0] packet_bits;
  logic width_reserved, capture_enable_bit, trigger_seen, acquisition_done_flag, tdo, tdo_oe;
  logic [39:0] x;
  logic [31:0] r;
  logic [31:0] words [8];
  logic b;
  int num_errors = 0, tests_run = 0, nw = 0, wcount = 0, rdcount = 0, cycles = 0;

  always #20 sys_clk = ~sys_clk;

  trace_capture_ctrl #(.ADDR_W(10), .DATA_W(32), .ID_VALUE(ID)) u_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .packet_width_select(packet_width_select),
    .generic_source(generic_source), .trigger_event(trigger_event),
    .word_complete_strobe(word_complete_strobe), .trace_packet_bus(trace_packet_bus),
    .packet_bits(packet_bits), .width_reserved(width_reserved),
    .capture_enable_bit(capture_enable_bit), .trigger_seen(trigger_seen),
    .acquisition_done_flag(acquisition_done_flag), .ram_req(ram_req), .ram_dout(ram_dout),
    .selftest_takeover(selftest_takeover), .selftest_req(selftest_req),
    .selftest_dout(selftest_dout), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe));
  trace_ram_model u_ram (.sys_clk(sys_clk), .ram_req(ram_req), .ram_dout(ram_dout));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [5:0] wexp(input logic [3:0] c);
    if (c[3]) return 6'h20;
    case (c[2:0])
      `TRC_PW_4: return `TRC_BITS_4;
      `TRC_PW_8: return `TRC_BITS_8;
      `TRC_PW_16: return `TRC_BITS_16;
      default: return 6'h00;
    endcase
  endfunction

  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // tck high for five cycles and low for at least six keeps well inside the pin synchroniser's reach
  task automatic tclk(input logic m, input logic d, output logic o);
    @(negedge sys_clk);
    tms = m;
    tdi = d;
    repeat (5) @(negedge sys_clk);
    o = tdo;
    tck = 1;
    repeat (5) @(negedge sys_clk);
    tck = 0;
  endtask
  task automatic shift(input logic ir, input logic [39:0] din, input int len,
                       output logic [39:0] dout);
    logic t;
    dout = '0;
    tclk(1, 0, t);
    if (ir) tclk(1, 0, t);
    tclk(0, 0, t);
    tclk(0, 0, t);
    for (int i = 0; i < len; i++) begin
      tclk(i == len - 1, din[i], t);
      dout[i] = t;
    end
    tclk(1, 0, t);
    tclk(0, 0, t);
  endtask
  task automatic ir(input logic [3:0] ins);
    logic [39:0] d;
    shift(1, {36'h0, ins}, 4, d);
    `CHK(d[3:0], `TRC_IR_CAPTURE)
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    logic [39:0] d2;
    shift(0, {1'b1, a, d}, 40, d2);
  endtask
  // read result shows up in the capture of the following scan
  task automatic rd(input logic [6:0] a, output logic [31:0] q);
    logic [39:0] d;
    shift(0, {1'b0, a, 32'h0}, 40, d);
    shift(0, {1'b0, `TRC_REG_STATUS, 32'h0}, 40, d);
    q = d[31:0];
  endtask
  task automatic strobe(input logic exp_we);
    @(negedge sys_clk);
    seed = lfsr(seed);
    trace_packet_bus = seed;
    word_complete_strobe = 1;
    #1;
    `CHK(ram_req.we, exp_we)
    if (exp_we) begin
      `CHK(ram_req.addr, 10'h005 + 10'(nw))
      words[nw] = seed;
      nw++;
    end
    @(negedge sys_clk);
    word_complete_strobe = 0;
    @(negedge sys_clk);
  endtask

  always @(posedge sys_clk) begin
    if (ram_req.we === 1'b1 && !selftest_takeover) wcount++;
    if (ram_req.ce === 1'b1 && ram_req.we === 1'b0 && !selftest_takeover) rdcount++;
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      summarize();
    end
  end

  initial begin
    repeat (8) @(negedge sys_clk);
    reset_n = 1;
    @(negedge sys_clk);
    `CHK({capture_enable_bit, trigger_seen, acquisition_done_flag, tdo_oe}, 4'h0)
    tclk(0, 0, b);
    shift(0, 40'h0, 32, x);
    `CHK(x[31:0], ID)
    ir(`TRC_INS_BYPASS);
    shift(0, 40'h3, 2, x);
    `CHK(x[1:0], 2'b10)
    ir(`TRC_INS_SCAN_N);
    shift(0, {35'h0, `TRC_CHAIN0}, 5, x);
    ir(`TRC_INS_CHAIN);
    for (int c = 0; c < 16; c++) begin
      @(negedge sys_clk);
      packet_width_select = c[2:0];
      generic_source = c[3];
      repeat (2) @(negedge sys_clk);
      `CHK(packet_bits, wexp(c[3:0]))
      `CHK(width_reserved, c[2:0] > 3'h2 && !c[3])
    end
    packet_width_select = `TRC_PW_8;
    generic_source = 0;
    wr(`TRC_REG_WRPTR, 32'h5);
    wr(`TRC_REG_TRIGCNT, 32'h3);
    wr(`TRC_REG_CTRL, 32'h1);
    for (int i = 0; i < 50 && capture_enable_bit !== 1'b1; i++) @(negedge sys_clk);
    `CHK(capture_enable_bit, 1'b1)
    repeat (2) strobe(1);
    @(negedge sys_clk);
    trigger_event = 1;
    @(negedge sys_clk);
    trigger_event = 0;
    @(negedge sys_clk);
    `CHK(trigger_seen, 1'b1)
    repeat (3) strobe(1);
    `CHK(acquisition_done_flag, 1'b1)
    repeat (2) strobe(0);
    rd(`TRC_REG_STATUS, r);
    `CHK(r[1:0], 2'b11)
    wr(`TRC_REG_CTRL, 32'h0);
    repeat (3) @(negedge sys_clk);
    `CHK({trigger_seen, acquisition_done_flag}, 2'b00)
    rd(`TRC_REG_WRPTR, r);
    `CHK(r[9:0], 10'h00A)
    `CHK(wcount, 5)
    rdcount = 0;
    wr(`TRC_REG_RDPTR, 32'h5);
    `CHK(rdcount, 1)
    rd(`TRC_REG_RAMDATA, r);
    `CHK(r, words[0])
    rd(`TRC_REG_RDPTR, r);
    `CHK(r[9:0], 10'h006)
    `CHK(rdcount, 2)
    @(negedge sys_clk);
    seed = lfsr(seed);
    selftest_req = {1'b1, 1'b0, 10'h005, seed};
    selftest_takeover = 1;
    #1;
    `CHK(ram_req, selftest_req)
    @(negedge sys_clk);
    `CHK(selftest_dout, words[0])
    selftest_takeover = 0;
    summarize();
  end
endmodule
`default_nettype wire
